// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    import tsp_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, mHsel = 1'b0, mHwrite = 1'b0;
    logic [31:0] mHaddr = 32'h0000_0000, mHwdata = 32'h0000_0000;
    logic [1:0] mHtrans = 2'h0, chanIn = 2'h0;
    logic [3:0] internalTriggers = 4'h0, gap = 4'h0;
    logic extTriggerIn = 1'b0, coreHalted = 1'b0, debugHoldBit = 1'b0;
    logic dmaOwn = 1'b0, dmaGo = 1'b0;
    logic [15:0] wordBase = 16'h0040;
    logic dHsel, hreadyout, dmaReq, outputPrepareSignal, counterRunning;
    logic hresp;
    logic [31:0] dHaddr, dHwdata, hrdata;
    logic [1:0] dHtrans;
    logic [15:0] nDone, counterValue;
    int failCount = 0;
    int nTests = 0;

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    // the bus belongs to the dma model only while dmaOwn is high
    tsp_timer_slave #(.INST(0)) tsp_timer_slave_i (
        .clk(clk), .sys_rst(sys_rst), .hsel(dmaOwn ? dHsel : mHsel),
        .haddr(dmaOwn ? dHaddr : mHaddr),
        .htrans(dmaOwn ? dHtrans : mHtrans),
        .hwrite(dmaOwn ? 1'b1 : mHwrite), .hsize(3'h2),
        .hwdata(dmaOwn ? dHwdata : mHwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .internalTriggers(internalTriggers), .chanIn(chanIn),
        .extTriggerIn(extTriggerIn), .coreHalted(coreHalted),
        .debugHoldBit(debugHoldBit), .dmaReq(dmaReq),
        .outputPrepareSignal(outputPrepareSignal),
        .counterValue(counterValue), .counterRunning(counterRunning));

    tsp_dma_model tsp_dma_model_i (
        .clk(clk), .sys_rst(sys_rst), .go(dmaGo), .gap(gap),
        .wordBase(wordBase),
        .dmaReq(dmaReq), .hready(hreadyout), .hsel(dHsel), .haddr(dHaddr),
        .htrans(dHtrans), .hwdata(dHwdata), .nDone(nDone));

    task automatic finishTest();
        if (failCount == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        nTests++;
        if (g !== e) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkb(input string n, input logic e, g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // waits for hready high at an edge; running out counts as a mismatch
    task automatic waitReady();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        chkb("hready", 1'b1, hreadyout);
    endtask

    // one single transfer; hsel stays up so back-to-back calls never
    // assign it twice in one step
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        mHsel <= 1'b1;
        mHtrans <= 2'h2;
        mHaddr <= a;
        mHwrite <= w;
        waitReady();
        mHtrans <= 2'h0;
        mHwdata <= d;
        waitReady();
        r = hrdata;
        chkb("hresp", 1'b0, hresp);
        mHwdata <= ~d;
    endtask

    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        logic [31:0] r;
        bus(BASE_INST0 + {25'h0, i, 2'h0}, 1'b1, d, r);
    endtask

    task automatic rd(input logic [4:0] i, output logic [31:0] r);
        bus(BASE_INST0 + {25'h0, i, 2'h0}, 1'b0, 32'h0000_0000, r);
    endtask

    task automatic setSrc(input logic [2:0] s, input logic v);
        case (s)
            3'h4, 3'h5: chanIn[0] <= v;
            3'h6: chanIn[1] <= v;
            3'h7: extTriggerIn <= v;
            default: internalTriggers[s[1:0]] <= v;
        endcase
    endtask

    task automatic waitStop();
        int k;
        k = 0;
        waitc(4);
        while (counterRunning !== 1'b0 && k < 80) begin
            waitc(1);
            k++;
        end
        chkb("stopped", 1'b0, counterRunning);
    endtask

    task automatic waitN(input logic [15:0] n);
        int k;
        k = 0;
        while (nDone !== n && k < 300) begin
            waitc(1);
            k++;
        end
        chk("dma writes", {16'h0, n}, {16'h0, nDone});
    endtask

    // hang guard, far beyond the several hundred cycles of the run
    initial begin
        waitc(60000);
        failCount++;
        finishTest();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        logic [2:0] src;
        waitc(16);
        sys_rst <= 1'b0;
        waitc(1);
        wr(IDX_CTL0, 32'h0000_0001);
        for (int s = 0; s < 8; s++) begin
            src = s[2:0];
            wr(IDX_SMCFG, {25'h0, src, 1'b0, SMC_RESTART});
            waitc(24);
            chkb("cnt before", 1'b1, counterValue > 16'h0014);
            setSrc(src, 1'b1);
            waitc(6);
            chkb("cnt restart", 1'b1, counterValue < 16'h0008);
            setSrc(src, 1'b0);
            rd(IDX_STAT, r);
            chkb("trg flag", 1'b1, r[STAT_TRG]);
            wr(IDX_STAT, 32'h0000_0000);
        end
        // pause on filtered channel 0, then a short glitch and inversion
        wr(IDX_SMCFG, {25'h0, TRG_CH0_FILT, 1'b0, SMC_PAUSE});
        waitc(4);
        v = counterValue;
        waitc(8);
        chk("paused", {16'h0, v}, {16'h0, counterValue});
        chanIn[0] <= 1'b1;
        waitc(4);
        v = counterValue;
        waitc(8);
        chk("running", {16'h0, v + 16'h0008}, {16'h0, counterValue});
        wr(IDX_CHCTL0, 32'h0000_3000);
        v = counterValue;
        chanIn[0] <= 1'b0;
        waitc(2);
        chanIn[0] <= 1'b1;
        waitc(8);
        chk("glitch", {16'h0, v + 16'h000A}, {16'h0, counterValue});
        wr(IDX_CHCTL2, 32'h0000_0002);
        waitc(8);
        chkb("inverted", 1'b0, counterRunning);
        wr(IDX_CHCTL2, 32'h0000_0000);
        wr(IDX_CHCTL0, 32'h0000_0000);
        waitc(8);
        coreHalted <= 1'b1;
        waitc(3);
        chkb("no hold", 1'b1, counterRunning);
        debugHoldBit <= 1'b1;
        waitc(2);
        v = counterValue;
        waitc(6);
        chk("held", {16'h0, v}, {16'h0, counterValue});
        coreHalted <= 1'b0;
        debugHoldBit <= 1'b0;
        // event mode on the inverted external trigger
        wr(IDX_CTL0, 32'h0000_0000);
        extTriggerIn <= 1'b1;
        wr(IDX_SMCFG, {16'h0, 1'b1, 7'h0, 1'b0, TRG_EXT, 1'b0, SMC_EVENT});
        waitc(6);
        rd(IDX_CTL0, r);
        chkb("evt idle", 1'b0, r[CTL0_CEN]);
        extTriggerIn <= 1'b0;
        waitc(8);
        rd(IDX_CTL0, r);
        chkb("evt start", 1'b1, r[CTL0_CEN]);
        // second reset in mid-run, then decode of foreign addresses
        sys_rst <= 1'b1;
        waitc(2);
        sys_rst <= 1'b0;
        waitc(1);
        chk("cnt rst", 32'h0, {16'h0, counterValue});
        bus(BASE_INST1 + 32'h0000_002C, 1'b1, 32'h0000_1234, r);
        rd(IDX_CAR, r);
        chk("car rst", 32'h0000_FFFF, r);
        bus(BASE_INST1 + 32'h0000_002C, 1'b0, 32'h0, r);
        chk("other base", 32'h0, r);
        bus(BASE_INST0 + 32'h0000_007C, 1'b0, 32'h0, r);
        chk("unmapped", 32'h0, r);
        // single pulse: stops and clears itself at the update
        wr(IDX_CAR, 32'h0000_0014);
        wr(IDX_CTL0, 32'h0000_0009);
        waitStop();
        chk("pulse cnt", 32'h0, {16'h0, counterValue});
        rd(IDX_CTL0, r);
        chk("pulse ctl", 32'h0000_0008, r);
        // fast compare, honoured in pwm mode 1, ignored in set mode
        wr(IDX_CV0, 32'h0000_0010);
        wr(IDX_CHCTL0, {25'h0, CMP_PWM1, 4'h4});
        wr(IDX_SMCFG, {25'h0, 3'h0, 1'b0, SMC_RESTART});
        waitc(2);
        chkb("pre idle", 1'b0, outputPrepareSignal);
        internalTriggers[0] <= 1'b1;
        waitc(3);
        chkb("fast pre", 1'b1, outputPrepareSignal);
        internalTriggers[0] <= 1'b0;
        waitStop();
        wr(IDX_CHCTL0, 32'h0000_0014);
        v[0] = outputPrepareSignal;
        internalTriggers[0] <= 1'b1;
        waitc(3);
        chkb("fast off", v[0], outputPrepareSignal);
        internalTriggers[0] <= 1'b0;
        waitStop();
        // software stop holds the count
        wr(IDX_SMCFG, 32'h0000_0000);
        wr(IDX_CTL0, 32'h0000_0001);
        waitc(5);
        wr(IDX_CTL0, 32'h0000_0000);
        waitc(2);
        v = counterValue;
        waitc(5);
        chk("sw stop", {16'h0, v}, {16'h0, counterValue});
        chkb("sw nonzero", 1'b1, v != 16'h0000);
        // two dma bursts of three words from CAR onwards
        wr(IDX_CAR, 32'h0000_0020);
        wr(IDX_DMACFG, {19'h0, 5'h02, 3'h0, IDX_CAR});
        wr(IDX_DMAEN, 32'h0000_0100);
        wr(IDX_CTL0, 32'h0000_0001);
        dmaOwn <= 1'b1;
        dmaGo <= 1'b1;
        waitN(16'h0003);
        gap <= 4'h5;
        waitc(2);
        chkb("req done", 1'b0, dmaReq);
        waitN(16'h0006);
        dmaGo <= 1'b0;
        waitc(4);
        dmaOwn <= 1'b0;
        waitc(1);
        wr(IDX_CTL0, 32'h0000_0000);
        rd(IDX_CAR, r);
        chk("burst car", {16'h0, wordBase + 16'h0003}, r);
        rd(IDX_CV0, r);
        chk("burst cv", {16'h0, wordBase + 16'h0005}, r);
        finishTest();
    end
endmodule

// >>> dv/tsp_dma_model.sv
`timescale 1ns/1ps
module tsp_dma_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control from the bench
    input wire logic go,
    input wire logic [3:0] gap,
    input wire logic [15:0] wordBase,
    // request and bus
    input wire logic dmaReq,
    input wire logic hready,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic [31:0] hwdata,
    output logic [15:0] nDone
);
    import tsp_pkg::*;
    logic [1:0] phase_q;
    logic [3:0] wt_q;
    // one word per request; the pause after each write keeps a falling
    // request from being taken twice
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= 2'h0;
            wt_q <= 4'h0;
            nDone <= 16'h0000;
            hsel <= 1'b0;
            htrans <= 2'h0;
            haddr <= 32'h0000_0000;
            hwdata <= 32'h0000_0000;
        end else if (phase_q == 2'h0) begin
            if (wt_q != 4'h0) begin
                wt_q <= wt_q - 4'h1;
            end else if (go && dmaReq) begin
                // memory to peripheral, aimed at the buffer
                hsel <= 1'b1;
                htrans <= 2'h2;
                haddr <= BASE_INST0 + {25'h0, IDX_DMATB, 2'h0};
                phase_q <= 2'h1;
            end
        end else if (hready) begin
            if (phase_q == 2'h1) begin
                htrans <= 2'h0;
                hwdata <= {16'h0000, wordBase + nDone};
                phase_q <= 2'h2;
            end else begin
                // released data no longer shows the last word
                hsel <= 1'b0;
                hwdata <= ~hwdata;
                nDone <= nDone + 16'h0001;
                wt_q <= gap + 4'h1;
                phase_q <= 2'h0;
            end
        end
    end
endmodule

// >>> rtl/tsp_filter.sv
`timescale 1ns/1ps
module tsp_filter #(
    parameter int CW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sample and setting
    input wire logic [CW-1:0] cfg,
    input wire logic din,
    // filtered level
    output logic dout
);
    typedef struct packed {
        logic [CW-1:0] run;
        logic level;
    } tsp_flt_t;
    tsp_flt_t s_q, s_d;

    // level moves only after cfg+1 agreeing samples; zero is a bypass
    always_comb begin
        s_d = s_q;
        if (din == s_q.level) begin
            s_d.run = '0;
        end else if (s_q.run >= cfg) begin
            s_d.level = din;
            s_d.run = '0;
        end else begin
            s_d.run = s_q.run + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.level;
endmodule

// >>> rtl/tsp_pkg.sv
package tsp_pkg;
    // register word indices, byte address is four times the index
    localparam logic [4:0] IDX_CTL0 = 5'h00;
    localparam logic [4:0] IDX_SMCFG = 5'h02;
    localparam logic [4:0] IDX_DMAEN = 5'h03;
    localparam logic [4:0] IDX_STAT = 5'h04;
    localparam logic [4:0] IDX_CHCTL0 = 5'h06;
    localparam logic [4:0] IDX_CHCTL2 = 5'h08;
    localparam logic [4:0] IDX_CNT = 5'h09;
    localparam logic [4:0] IDX_CAR = 5'h0B;
    localparam logic [4:0] IDX_CV0 = 5'h0D;
    localparam logic [4:0] IDX_DMACFG = 5'h12;
    localparam logic [4:0] IDX_DMATB = 5'h13;

    // instance base addresses, one per timer instance
    localparam logic [31:0] BASE_INST0 = 32'h4000_0000;
    localparam logic [31:0] BASE_INST1 = 32'h4000_0400;
    localparam logic [31:0] BASE_INST2 = 32'h4000_0800;
    localparam logic [31:0] BASE_INST3 = 32'h4000_0C00;

    // field positions
    localparam int CTL0_CEN = 0;
    localparam int CTL0_SPM = 3;
    localparam int SMC_LSB = 0;
    localparam int TRGS_LSB = 4;
    localparam int EXT_FILTER_CFG_LSB = 8;
    localparam int EXT_PRESCALE_CFG_LSB = 12;
    localparam int ETP_BIT = 15;
    localparam int DMAEN_UPD = 8;
    localparam int STAT_UPD = 0;
    localparam int STAT_TRG = 6;
    localparam int CH_FAST = 2;
    localparam int CH_MODE_LSB = 4;
    localparam int CH_FLT_LSB = 12;
    localparam int CH_P0 = 1;
    localparam int CH_NP0 = 3;
    localparam int CH_P1 = 5;
    localparam int CH_NP1 = 7;
    localparam int DMA_START_LSB = 0;
    localparam int DMA_COUNT_LSB = 8;

    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_CAR = 16'hFFFF;

    // slave modes, trigger sources and pwm compare modes
    localparam logic [2:0] SMC_RESTART = 3'b100;
    localparam logic [2:0] SMC_PAUSE = 3'b101;
    localparam logic [2:0] SMC_EVENT = 3'b110;
    localparam logic [2:0] TRG_CH0_EDGE = 3'b100;
    localparam logic [2:0] TRG_CH0_FILT = 3'b101;
    localparam logic [2:0] TRG_CH1_FILT = 3'b110;
    localparam logic [2:0] TRG_EXT = 3'b111;
    localparam logic [2:0] CMP_PWM0 = 3'b110;
    localparam logic [2:0] CMP_PWM1 = 3'b111;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT, BUS_RDDONE}
        tsp_bus_t;
endpackage

// >>> rtl/tsp_prescale.sv
`timescale 1ns/1ps
module tsp_prescale (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ratio code: rising edges divided by 1, 2, 4 or 8
    input wire logic [1:0] psc,
    input wire logic din,
    // divided level
    output logic dout
);
    typedef struct packed {
        logic prev;
        logic [2:0] edges;
        logic level;
    } tsp_psc_t;
    tsp_psc_t s_q, s_d;

    // a bit of the edge count rises once per 2^psc input edges
    always_comb begin
        s_d = s_q;
        s_d.prev = din;
        if (din && !s_q.prev) begin
            s_d.edges = s_q.edges + 1'b1;
        end
        case (psc)
            2'h0: s_d.level = din;
            2'h1: s_d.level = s_d.edges[0];
            2'h2: s_d.level = s_d.edges[1];
            default: s_d.level = s_d.edges[2];
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.level;
endmodule

// >>> rtl/tsp_timer_slave.sv
`timescale 1ns/1ps
module tsp_timer_slave #(
    parameter int INST = 0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // trigger inputs
    input wire logic [3:0] internalTriggers,
    input wire logic [1:0] chanIn,
    input wire logic extTriggerIn,
    // debug halt
    input wire logic coreHalted,
    input wire logic debugHoldBit,
    // dma handshake
    output logic dmaReq,
    // timer outputs
    output logic outputPrepareSignal,
    output logic [15:0] counterValue,
    output logic counterRunning
);
    import tsp_pkg::*;

    // base decode per instance
    localparam logic [31:0] BASE = (INST == 0) ? BASE_INST0 :
        (INST == 1) ? BASE_INST1 : (INST == 2) ? BASE_INST2 : BASE_INST3;

    typedef struct packed {
        logic [15:0] ctl0;
        logic [15:0] smcfg;
        logic [15:0] dmaen;
        logic [15:0] chctl0;
        logic [15:0] chctl2;
        logic [15:0] car;
        logic [15:0] cv0;
        logic [15:0] dmacfg;
        logic [15:0] cnt;
        logic statUpd;
        logic statTrg;
        logic trgPrev;
        logic ch0Prev;
        logic edgeDly;
        logic ocPrep;
        logic fastHold;
        logic [5:0] dmaLeft;
        logic [4:0] dmaIdx;
        tsp_bus_t bus;
        logic [4:0] aIdx;
        logic aHit;
        logic [31:0] rdata;
    } tsp_state_t;
    tsp_state_t s_q, s_d;

    logic [1:0] chFilt;
    logic extFilt, extDiv;
    logic selLvl, bothEdges, trgEdge, halted, run, updEvt, dmaEvt;
    logic fastFire, matchLvl, isPwm, bufAccess;
    logic [2:0] smc, trgs, cmpMode;
    logic [4:0] effIdx;

    // channel filters share the capture filter field
    for (genvar c = 0; c < 2; c++) begin : g_chflt
        tsp_filter #(.CW(4)) u_flt_ch (
            .clk(clk),
            .sys_rst(sys_rst),
            .cfg(s_q.chctl0[CH_FLT_LSB +: 4]),
            .din(chanIn[c]),
            .dout(chFilt[c])
        );
    end
    // external trigger: polarity, own filter then own prescaler
    tsp_filter #(.CW(4)) u_flt_ext (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg(s_q.smcfg[EXT_FILTER_CFG_LSB +: 4]),
        .din(extTriggerIn ^ s_q.smcfg[ETP_BIT]),
        .dout(extFilt)
    );
    tsp_prescale u_psc_ext (
        .clk(clk),
        .sys_rst(sys_rst),
        .psc(s_q.smcfg[EXT_PRESCALE_CFG_LSB +: 2]),
        .din(extFilt),
        .dout(extDiv)
    );

    assign smc = s_q.smcfg[SMC_LSB +: 3];
    assign trgs = s_q.smcfg[TRGS_LSB +: 3];
    assign cmpMode = s_q.chctl0[CH_MODE_LSB +: 3];
    assign halted = coreHalted && debugHoldBit;

    // trigger source mux; internal triggers unfiltered
    always_comb begin
        bothEdges = 1'b0;
        case (trgs)
            TRG_CH0_EDGE: selLvl = chFilt[0] ^ s_q.ch0Prev;
            TRG_CH0_FILT: begin
                selLvl = chFilt[0] ^ s_q.chctl2[CH_P0];
                bothEdges = s_q.chctl2[CH_P0] && s_q.chctl2[CH_NP0];
            end
            TRG_CH1_FILT: begin
                selLvl = chFilt[1] ^ s_q.chctl2[CH_P1];
                bothEdges = s_q.chctl2[CH_P1] && s_q.chctl2[CH_NP1];
            end
            TRG_EXT: selLvl = extDiv;
            default: selLvl = internalTriggers[trgs[1:0]];
        endcase
    end

    // valid edge only in one of the three slave modes
    assign trgEdge = smc[2] && (smc != 3'b111) &&
        (bothEdges ? (selLvl != s_q.trgPrev) : (selLvl && !s_q.trgPrev));

    // pause gates counting on the trigger level; debug hold freezes
    assign run = s_q.ctl0[CTL0_CEN] && !halted &&
        !(smc == SMC_PAUSE && !selLvl);
    assign updEvt = run && (s_q.cnt == s_q.car);
    assign dmaEvt = updEvt && s_q.dmaen[DMAEN_UPD];

    // fast compare only for pwm outputs started by a trigger
    assign isPwm = (cmpMode == CMP_PWM0) || (cmpMode == CMP_PWM1);
    assign matchLvl = (cmpMode == CMP_PWM1);
    assign fastFire = s_q.chctl0[CH_FAST] && isPwm && s_q.ctl0[CTL0_SPM] &&
        trgEdge && !s_q.ctl0[CTL0_CEN];

    // buffer accesses redirected to start plus burst step
    assign effIdx = (s_q.aIdx == IDX_DMATB) ?
        s_q.dmacfg[DMA_START_LSB +: 5] + s_q.dmaIdx : s_q.aIdx;
    assign bufAccess = s_q.aHit && (s_q.aIdx == IDX_DMATB) &&
        (s_q.bus == BUS_WRITE || s_q.bus == BUS_RDWAIT);

    // register read view; unmapped words read zero
    function automatic logic [31:0] readReg(input tsp_state_t s,
                                            input logic [4:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            IDX_CTL0: v = s.ctl0;
            IDX_SMCFG: v = s.smcfg;
            IDX_DMAEN: v = s.dmaen;
            IDX_STAT: begin
                v[STAT_UPD] = s.statUpd;
                v[STAT_TRG] = s.statTrg;
            end
            IDX_CHCTL0: v = s.chctl0;
            IDX_CHCTL2: v = s.chctl2;
            IDX_CNT: v = s.cnt;
            IDX_CAR: v = s.car;
            IDX_CV0: v = s.cv0;
            IDX_DMACFG: v = s.dmacfg;
            default: v = 16'h0000;
        endcase
        return {16'h0000, v};
    endfunction

    // next state: bus first, then hardware events which win over software
    always_comb begin
        s_d = s_q;
        s_d.trgPrev = selLvl;
        s_d.ch0Prev = chFilt[0];
        s_d.edgeDly = trgEdge;
        // data phase of a write, or read data capture
        if (s_q.bus == BUS_WRITE && s_q.aHit) begin
            case (effIdx)
                IDX_CTL0: s_d.ctl0 = hwdata[15:0];
                IDX_SMCFG: s_d.smcfg = hwdata[15:0];
                IDX_DMAEN: s_d.dmaen = hwdata[15:0];
                IDX_STAT: begin
                    s_d.statUpd = s_q.statUpd && hwdata[STAT_UPD];
                    s_d.statTrg = s_q.statTrg && hwdata[STAT_TRG];
                end
                IDX_CHCTL0: s_d.chctl0 = hwdata[15:0];
                IDX_CHCTL2: s_d.chctl2 = hwdata[15:0];
                IDX_CAR: s_d.car = hwdata[15:0];
                IDX_CV0: s_d.cv0 = hwdata[15:0];
                IDX_DMACFG: s_d.dmacfg = hwdata[15:0];
                default: s_d.cv0 = s_d.cv0;
            endcase
        end
        if (s_q.bus == BUS_RDWAIT) begin
            s_d.rdata = s_q.aHit ? readReg(s_q, effIdx) : 32'h0000_0000;
        end
        // bus sequencing; reads take one wait state
        case (s_q.bus)
            BUS_RDWAIT: s_d.bus = BUS_RDDONE;
            default: s_d.bus = BUS_IDLE;
        endcase
        if (hsel && htrans[1] && s_q.bus != BUS_RDWAIT) begin
            s_d.aIdx = haddr[6:2];
            s_d.aHit = (haddr[31:10] == BASE[31:10]) &&
                (haddr[9:7] == 3'h0);
            s_d.bus = hwrite ? BUS_WRITE : BUS_RDWAIT;
        end
        // burst stepping on each buffer access
        if (bufAccess && s_q.dmaLeft != 6'h00) begin
            s_d.dmaLeft = s_q.dmaLeft - 1'b1;
            s_d.dmaIdx = s_q.dmaIdx + 1'b1;
        end
        // a new event restarts the burst at the start address
        if (dmaEvt) begin
            s_d.dmaLeft = {1'b0, s_q.dmacfg[DMA_COUNT_LSB +: 5]} + 6'h01;
            s_d.dmaIdx = 5'h00;
        end
        // counter: software clear just stops it, value held
        if (run) begin
            if (updEvt) begin
                s_d.cnt = 16'h0000; // reinitialised on update
                s_d.statUpd = 1'b1;
                if (s_q.ctl0[CTL0_SPM]) begin
                    s_d.ctl0[CTL0_CEN] = 1'b0;
                end
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
        if (smc == SMC_RESTART && trgEdge && !halted) begin
            s_d.cnt = 16'h0000;
        end
        // trigger sets the enable in event mode or single pulse
        if (trgEdge && (smc == SMC_EVENT || s_q.ctl0[CTL0_SPM])) begin
            s_d.ctl0[CTL0_CEN] = 1'b1;
        end
        // flag two cycles after the edge; set beats clear
        if (s_q.edgeDly) begin
            s_d.statTrg = 1'b1;
        end
        // output prepare from compare mode
        case (cmpMode)
            3'h1: if (s_q.cnt == s_q.cv0) s_d.ocPrep = 1'b1;
            3'h2: if (s_q.cnt == s_q.cv0) s_d.ocPrep = 1'b0;
            3'h3: if (s_q.cnt == s_q.cv0 && run) s_d.ocPrep = !s_q.ocPrep;
            3'h4: s_d.ocPrep = 1'b0;
            3'h5: s_d.ocPrep = 1'b1;
            CMP_PWM0: s_d.ocPrep = (s_q.cnt < s_q.cv0);
            CMP_PWM1: s_d.ocPrep = (s_q.cnt >= s_q.cv0);
            default: s_d.ocPrep = s_q.ocPrep;
        endcase
        // forced level held until the compare would reach it anyway
        if (s_q.fastHold) begin
            s_d.ocPrep = matchLvl;
            if (s_q.cnt >= s_q.cv0 || updEvt) begin
                s_d.fastHold = 1'b0;
            end
        end
        if (fastFire) begin
            s_d.ocPrep = matchLvl;
            s_d.fastHold = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.car <= RST_CAR;
            s_q.ctl0 <= RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; response is always okay, request holds until served
    assign hrdata = s_q.rdata;
    assign hreadyout = (s_q.bus != BUS_RDWAIT);
    assign hresp = 1'b0;
    assign dmaReq = (s_q.dmaLeft != 6'h00);
    assign outputPrepareSignal = s_q.ocPrep;
    assign counterValue = s_q.cnt;
    assign counterRunning = run;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_trg_edge;
        trgEdge;
    endsequence
    sequence s_flag_late;
        ##2 s_q.statTrg;
    endsequence

    a_restart_clear: assert property (
        s_trg_edge and smc == SMC_RESTART && !halted |=> s_q.cnt == 16'h0000)
        else $error("restart trigger did not clear the counter");
    a_pause_hold: assert property (
        smc == SMC_PAUSE && !selLvl && s_q.ctl0[CTL0_CEN] |=> $stable(s_q.cnt))
        else $error("counter moved while paused");
    a_event_enable: assert property (
        s_trg_edge and smc == SMC_EVENT |=> s_q.ctl0[CTL0_CEN])
        else $error("event trigger did not set enable");
    a_pulse_stop: assert property (
        updEvt && s_q.ctl0[CTL0_SPM] && !trgEdge
        |=> !s_q.ctl0[CTL0_CEN] && s_q.cnt == 16'h0000 ##1 $stable(s_q.cnt))
        else $error("single pulse did not stop at update");
    a_trig_flag: assert property (
        s_trg_edge |-> s_flag_late)
        else $error("trigger flag not set two cycles after edge");
    a_debug_freeze: assert property (
        halted |=> $stable(s_q.cnt))
        else $error("counter moved during debug halt");
    a_dma_count: assert property (
        dmaEvt |=> s_q.dmaLeft ==
        {1'b0, $past(s_q.dmacfg[DMA_COUNT_LSB +: 5])} + 6'h01)
        else $error("burst length wrong after event");
    a_dma_restart: assert property (
        dmaEvt |=> s_q.dmaIdx == 5'h00 && dmaReq)
        else $error("burst did not restart at start address");
    a_fast_force: assert property (
        fastFire |=> s_q.ocPrep == $past(matchLvl))
        else $error("fast compare did not force output prepare");
    a_read_wait: assert property (
        s_q.bus == BUS_RDWAIT |-> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
endmodule
